/* File: drive_ctrl_pkg.sv */
// Constants, types and object map of the drive device-control block.
// Assumes a 20 MHz core clock and one object-access request port.
package drive_ctrl_pkg;

  localparam int CLK_HZ      = 20_000_000;
  localparam int CLK_PER_MS  = CLK_HZ / 1000;
  localparam int LED_HALF_MS = 250;
  localparam int OFFS_ADJ_MS = 2;
  localparam int LED_HALF_CYC = LED_HALF_MS * CLK_PER_MS;
  localparam int OFFS_ADJ_CYC = OFFS_ADJ_MS * CLK_PER_MS;

  // Object indices and subindices
  localparam logic [15:0] IDX_MOTOR  = 16'h2350;
  localparam logic [15:0] IDX_ENC    = 16'h2351;
  localparam logic [15:0] IDX_FMASK  = 16'h2321;
  localparam logic [15:0] IDX_SD_OPT = 16'h605B;
  localparam logic [15:0] IDX_DO_OPT = 16'h605C;
  localparam logic [15:0] IDX_OFFS   = 16'h2503;
  localparam logic [15:0] IDX_CTRL   = 16'h6040;
  localparam logic [15:0] IDX_STATE  = 16'h6041;
  localparam logic [7:0]  SUB_0 = 8'h00;
  localparam logic [7:0]  SUB_1 = 8'h01;
  localparam logic [7:0]  SUB_2 = 8'h02;
  localparam logic [7:0]  SUB_3 = 8'h03;
  localparam logic [7:0]  SUB_5 = 8'h05;

  // Reset and fixed values
  localparam logic [7:0]  MOTOR_ENTRIES = 8'h05;
  localparam logic [7:0]  ENC_ENTRIES   = 8'h03;
  localparam logic [7:0]  SRC_HALL      = 8'h00;
  localparam logic [7:0]  SRC_EXT       = 8'h01;
  localparam logic [7:0]  SRC_BOTH      = 8'h0A;
  localparam logic [31:0] EXT_CNT_RST   = 32'h0000_0800;
  localparam logic [31:0] HALL_CNT      = 32'h0000_0BB8;
  localparam logic [15:0] FMASK_RST     = 16'h0000;
  localparam logic [15:0] OPT_RST       = 16'h0000;
  localparam logic        OFFS_ADJ_RST  = 1'b1;
  localparam logic [15:0] MOTOR_PAR_RST = 16'h0000;
  localparam logic [15:0] POLE_RST      = 16'h0002;

  // Command word and state word bit positions
  localparam int CW_SW_ON = 0;
  localparam int CW_EN_V  = 1;
  localparam int CW_QSTOP = 2;
  localparam int CW_EN_OP = 3;
  localparam int CW_FRST  = 7;
  localparam int CW_HALT  = 8;
  localparam int CW_LIFE  = 15;
  localparam int SW_LIFE  = 15;

  typedef enum logic [3:0] {
    NOT_READY     = 4'h0,
    SW_DISABLED   = 4'h1,
    READY         = 4'h2,
    SWITCHED_ON   = 4'h3,
    OP_ENABLED    = 4'h4,
    QUICK_STOP    = 4'h5,
    STOP_SHUTDOWN = 4'h6,
    STOP_DISABLE  = 4'h7,
    FAULT_REACT   = 4'h8,
    FAULT         = 4'h9
  } drv_state_t;

  typedef enum logic [2:0] {
    CMD_SHUTDOWN = 3'h0,
    CMD_SWITCH   = 3'h1,
    CMD_DISV     = 3'h2,
    CMD_QSTOP    = 3'h3,
    CMD_ENABLE   = 3'h4
  } drv_cmd_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] data;
  } obj_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] data;
  } obj_rsp_t;

  typedef struct packed {
    logic        stageEnable;
    logic        ledGreen;
    logic        stopRequest;
    logic        quickRamp;
    logic        cancelMoves;
    logic        suspendMoves;
    logic        offsetAdjust;
    logic [15:0] stateWord;
  } drive_out_t;

endpackage

/* File: cycle_timer.sv */
// Run-gated cycle timer: pulses done on the last cycle of each period.
// Assumes run comes from logic on core_clk.
`timescale 1ns/1ps
module cycle_timer #(
  parameter int CYCLES = 4
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic run,
  output logic      done
);
  localparam int W = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [W-1:0] cnt;
  } timer_state_t;

  timer_state_t q;
  timer_state_t nxt;

  assign done = run && (q.cnt == W'(CYCLES - 1));

  always_comb begin
    nxt = q;
    if (!run || done) begin
      nxt.cnt = '0;
    end else begin
      nxt.cnt = q.cnt + W'(1);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= nxt;
    end
  end
endmodule

/* File: drive_device_control_fsm.sv */
// Drive device-control state machine with motor and encoder objects.
// Assumes objReq, errorEvents and motorStopped come from core_clk logic;
// voltageOk is a raw pin.
`timescale 1ns/1ps
module drive_device_control_fsm #(
  parameter int          LED_HALF_CYCLES = drive_ctrl_pkg::LED_HALF_CYC,
  parameter int          OFFS_ADJ_CYCLES = drive_ctrl_pkg::OFFS_ADJ_CYC,
  parameter logic [15:0] SPEED_K_RST     = drive_ctrl_pkg::MOTOR_PAR_RST,
  parameter logic [15:0] TERM_R_RST      = drive_ctrl_pkg::MOTOR_PAR_RST,
  parameter logic [15:0] POLE_PITCH_RST  = drive_ctrl_pkg::POLE_RST,
  parameter logic [15:0] THERM_T_RST     = drive_ctrl_pkg::MOTOR_PAR_RST
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire drive_ctrl_pkg::obj_req_t   objReq,
  output drive_ctrl_pkg::obj_rsp_t        objRsp,
  input  wire logic                       voltageOk,
  input  wire logic [15:0]                errorEvents,
  input  wire logic                       motorStopped,
  output drive_ctrl_pkg::drive_out_t      drv
);

  typedef struct packed {
    drive_ctrl_pkg::drv_state_t st;
    logic [15:0]                ctrl;
    logic                       frstPrev;
    logic                       vSync1;
    logic                       vSync2;
    logic                       blink;
    logic [15:0]                faultMask;
    logic [15:0]                sdOpt;
    logic [15:0]                doOpt;
    logic                       offsAdj;
    logic [15:0]                speedK;
    logic [15:0]                termR;
    logic [15:0]                pole;
    logic [15:0]                thermT;
    logic [7:0]                 srcSel;
    logic [31:0]                extCnt;
    drive_ctrl_pkg::obj_rsp_t   rsp;
    drive_ctrl_pkg::drive_out_t out;
  } core_state_t;

  localparam core_state_t CORE_RST = '{
    st:        drive_ctrl_pkg::NOT_READY,
    faultMask: drive_ctrl_pkg::FMASK_RST,
    sdOpt:     drive_ctrl_pkg::OPT_RST,
    doOpt:     drive_ctrl_pkg::OPT_RST,
    offsAdj:   drive_ctrl_pkg::OFFS_ADJ_RST,
    speedK:    SPEED_K_RST,
    termR:     TERM_R_RST,
    pole:      POLE_PITCH_RST,
    thermT:    THERM_T_RST,
    srcSel:    drive_ctrl_pkg::SRC_HALL,
    extCnt:    drive_ctrl_pkg::EXT_CNT_RST,
    default:   '0
  };

  core_state_t              q;
  core_state_t              nxt;
  drive_ctrl_pkg::drv_cmd_t cmd;
  logic                     trip;
  logic                     frstRise;
  logic                     ledTick;
  logic                     offsDone;
  logic                     wr;
  logic                     ro;
  logic                     hit;
  logic                     bad;
  logic [31:0]              rdat;

  cycle_timer #(.CYCLES(LED_HALF_CYCLES)) u_led_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .run      (1'b1),
    .done     (ledTick)
  );

  // Offset readjustment holds the not-ready state for a fixed time
  cycle_timer #(.CYCLES(OFFS_ADJ_CYCLES)) u_offs_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .run      (q.st == drive_ctrl_pkg::NOT_READY && q.offsAdj),
    .done     (offsDone)
  );

  // Bit 1 low wins over everything, then bit 2 low, as the command table nests
  function automatic drive_ctrl_pkg::drv_cmd_t decode(input logic [15:0] c);
    drive_ctrl_pkg::drv_cmd_t r;
    if (!c[drive_ctrl_pkg::CW_EN_V]) begin
      r = drive_ctrl_pkg::CMD_DISV;
    end else if (!c[drive_ctrl_pkg::CW_QSTOP]) begin
      r = drive_ctrl_pkg::CMD_QSTOP;
    end else if (!c[drive_ctrl_pkg::CW_SW_ON]) begin
      r = drive_ctrl_pkg::CMD_SHUTDOWN;
    end else if (!c[drive_ctrl_pkg::CW_EN_OP]) begin
      r = drive_ctrl_pkg::CMD_SWITCH;
    end else begin
      r = drive_ctrl_pkg::CMD_ENABLE;
    end
    return r;
  endfunction

  assign cmd      = decode(q.ctrl);
  assign trip     = |(errorEvents & q.faultMask);
  assign frstRise = q.ctrl[drive_ctrl_pkg::CW_FRST] && !q.frstPrev;
  assign wr       = objReq.valid && objReq.write;
  assign objRsp   = q.rsp;
  assign drv      = q.out;

  always_comb begin
    nxt = q;
    nxt.vSync1 = voltageOk;
    nxt.vSync2 = q.vSync1;
    nxt.frstPrev = q.ctrl[drive_ctrl_pkg::CW_FRST];
    nxt.rsp = '0;
    nxt.out.cancelMoves = 1'b0;
    rdat = '0;
    ro = 1'b0;
    hit = 1'b1;
    bad = 1'b0;
    if (ledTick) begin
      nxt.blink = !q.blink;
    end

    // Transitions act on the held command word; unlisted pairs fall through unchanged
    case (q.st)
      drive_ctrl_pkg::NOT_READY: begin
        if (!q.offsAdj || offsDone) begin
          nxt.st = drive_ctrl_pkg::SW_DISABLED;
        end
      end
      drive_ctrl_pkg::SW_DISABLED: begin
        if (cmd == drive_ctrl_pkg::CMD_SHUTDOWN) begin
          nxt.st = drive_ctrl_pkg::READY;
        end
      end
      drive_ctrl_pkg::READY: begin
        // Enable held here goes through switched-on, and on next cycle if vSync2 is set
        if (cmd == drive_ctrl_pkg::CMD_SWITCH || cmd == drive_ctrl_pkg::CMD_ENABLE) begin
          nxt.st = drive_ctrl_pkg::SWITCHED_ON;
        end else if (cmd == drive_ctrl_pkg::CMD_DISV || cmd == drive_ctrl_pkg::CMD_QSTOP) begin
          nxt.st = drive_ctrl_pkg::SW_DISABLED;
        end
      end
      drive_ctrl_pkg::SWITCHED_ON: begin
        if (cmd == drive_ctrl_pkg::CMD_ENABLE && q.vSync2) begin
          nxt.st = drive_ctrl_pkg::OP_ENABLED;
        end else if (cmd == drive_ctrl_pkg::CMD_SHUTDOWN) begin
          nxt.st = drive_ctrl_pkg::READY;
        end else if (cmd == drive_ctrl_pkg::CMD_DISV || cmd == drive_ctrl_pkg::CMD_QSTOP) begin
          nxt.st = drive_ctrl_pkg::SW_DISABLED;
        end
      end
      drive_ctrl_pkg::OP_ENABLED: begin
        case (cmd)
          drive_ctrl_pkg::CMD_SWITCH: begin
            nxt.out.cancelMoves = 1'b1;
            nxt.st = (q.doOpt != '0) ? drive_ctrl_pkg::STOP_DISABLE : drive_ctrl_pkg::SWITCHED_ON;
          end
          drive_ctrl_pkg::CMD_SHUTDOWN: begin
            nxt.st = (q.sdOpt != '0) ? drive_ctrl_pkg::STOP_SHUTDOWN : drive_ctrl_pkg::READY;
          end
          drive_ctrl_pkg::CMD_DISV: begin
            nxt.st = drive_ctrl_pkg::SW_DISABLED;
          end
          drive_ctrl_pkg::CMD_QSTOP: begin
            nxt.out.cancelMoves = 1'b1;
            nxt.st = drive_ctrl_pkg::QUICK_STOP;
          end
          default: begin
            nxt.st = q.st;
          end
        endcase
      end
      drive_ctrl_pkg::STOP_SHUTDOWN: begin
        if (cmd == drive_ctrl_pkg::CMD_DISV) begin
          nxt.st = drive_ctrl_pkg::SW_DISABLED;
        end else if (motorStopped) begin
          nxt.st = drive_ctrl_pkg::READY;
        end
      end
      drive_ctrl_pkg::STOP_DISABLE: begin
        if (cmd == drive_ctrl_pkg::CMD_DISV) begin
          nxt.st = drive_ctrl_pkg::SW_DISABLED;
        end else if (motorStopped) begin
          nxt.st = drive_ctrl_pkg::SWITCHED_ON;
        end
      end
      drive_ctrl_pkg::QUICK_STOP: begin
        if (cmd == drive_ctrl_pkg::CMD_DISV) begin
          nxt.st = drive_ctrl_pkg::SW_DISABLED;
        end
      end
      drive_ctrl_pkg::FAULT_REACT: begin
        if (motorStopped) begin
          nxt.st = drive_ctrl_pkg::FAULT;
        end
      end
      drive_ctrl_pkg::FAULT: begin
        // A still-active error keeps the fault even on acknowledge
        if (frstRise && !trip) begin
          nxt.st = drive_ctrl_pkg::SW_DISABLED;
        end
      end
      default: begin
        nxt.st = drive_ctrl_pkg::SW_DISABLED;
      end
    endcase

    if (trip && q.st != drive_ctrl_pkg::FAULT_REACT && q.st != drive_ctrl_pkg::FAULT) begin
      nxt.st = drive_ctrl_pkg::FAULT_REACT;
      nxt.out.cancelMoves = 1'b1;
    end

    // Object access, answered one cycle later
    if (objReq.valid) begin
      case ({objReq.index, objReq.sub})
        {drive_ctrl_pkg::IDX_MOTOR, drive_ctrl_pkg::SUB_0}: begin
          rdat = 32'(drive_ctrl_pkg::MOTOR_ENTRIES);
          ro = 1'b1;
        end
        {drive_ctrl_pkg::IDX_MOTOR, drive_ctrl_pkg::SUB_1}: begin
          rdat = 32'(q.speedK);
          if (wr) nxt.speedK = objReq.data[15:0];
        end
        {drive_ctrl_pkg::IDX_MOTOR, drive_ctrl_pkg::SUB_2}: begin
          rdat = 32'(q.termR);
          if (wr) nxt.termR = objReq.data[15:0];
        end
        {drive_ctrl_pkg::IDX_MOTOR, drive_ctrl_pkg::SUB_3}: begin
          rdat = 32'(q.pole);
          if (wr) nxt.pole = objReq.data[15:0];
        end
        {drive_ctrl_pkg::IDX_MOTOR, drive_ctrl_pkg::SUB_5}: begin
          rdat = 32'(q.thermT);
          if (wr) nxt.thermT = objReq.data[15:0];
        end
        {drive_ctrl_pkg::IDX_ENC, drive_ctrl_pkg::SUB_0}: begin
          rdat = 32'(drive_ctrl_pkg::ENC_ENTRIES);
          ro = 1'b1;
        end
        {drive_ctrl_pkg::IDX_ENC, drive_ctrl_pkg::SUB_1}: begin
          rdat = 32'(q.srcSel);
          // Codes outside the supported combinations are refused
          if (wr) begin
            if (objReq.data[7:0] == drive_ctrl_pkg::SRC_HALL || objReq.data[7:0] == drive_ctrl_pkg::SRC_EXT
                || objReq.data[7:0] == drive_ctrl_pkg::SRC_BOTH) begin
              nxt.srcSel = objReq.data[7:0];
            end else begin
              bad = 1'b1;
            end
          end
        end
        {drive_ctrl_pkg::IDX_ENC, drive_ctrl_pkg::SUB_2}: begin
          rdat = q.extCnt;
          if (wr) nxt.extCnt = objReq.data;
        end
        {drive_ctrl_pkg::IDX_ENC, drive_ctrl_pkg::SUB_3}: begin
          rdat = drive_ctrl_pkg::HALL_CNT;
          ro = 1'b1;
        end
        {drive_ctrl_pkg::IDX_FMASK, drive_ctrl_pkg::SUB_2}: begin
          rdat = 32'(q.faultMask);
          if (wr) nxt.faultMask = objReq.data[15:0];
        end
        {drive_ctrl_pkg::IDX_SD_OPT, drive_ctrl_pkg::SUB_0}: begin
          rdat = 32'(q.sdOpt);
          if (wr) nxt.sdOpt = objReq.data[15:0];
        end
        {drive_ctrl_pkg::IDX_DO_OPT, drive_ctrl_pkg::SUB_0}: begin
          rdat = 32'(q.doOpt);
          if (wr) nxt.doOpt = objReq.data[15:0];
        end
        {drive_ctrl_pkg::IDX_OFFS, drive_ctrl_pkg::SUB_0}: begin
          rdat = 32'(q.offsAdj);
          if (wr) nxt.offsAdj = objReq.data[0];
        end
        {drive_ctrl_pkg::IDX_CTRL, drive_ctrl_pkg::SUB_0}: begin
          rdat = 32'(q.ctrl);
          if (wr) nxt.ctrl = objReq.data[15:0];
        end
        {drive_ctrl_pkg::IDX_STATE, drive_ctrl_pkg::SUB_0}: begin
          rdat = 32'(q.out.stateWord);
          ro = 1'b1;
        end
        default: begin
          hit = 1'b0;
        end
      endcase
      nxt.rsp.ack = 1'b1;
      nxt.rsp.err = !hit || (wr && ro) || bad;
      nxt.rsp.data = wr ? '0 : rdat;
    end

    // Outputs follow the next state so they line up with it
    nxt.out.stageEnable = (nxt.st == drive_ctrl_pkg::OP_ENABLED) || (nxt.st == drive_ctrl_pkg::QUICK_STOP)
                          || (nxt.st == drive_ctrl_pkg::STOP_SHUTDOWN) || (nxt.st == drive_ctrl_pkg::STOP_DISABLE)
                          || (nxt.st == drive_ctrl_pkg::FAULT_REACT && q.out.stageEnable);
    nxt.out.stopRequest = (nxt.st == drive_ctrl_pkg::STOP_SHUTDOWN) || (nxt.st == drive_ctrl_pkg::STOP_DISABLE)
                          || (nxt.st == drive_ctrl_pkg::FAULT_REACT);
    nxt.out.quickRamp = (nxt.st == drive_ctrl_pkg::QUICK_STOP);
    nxt.out.suspendMoves = (nxt.st == drive_ctrl_pkg::OP_ENABLED) && nxt.ctrl[drive_ctrl_pkg::CW_HALT];
    nxt.out.offsetAdjust = (nxt.st == drive_ctrl_pkg::NOT_READY) && nxt.offsAdj;
    nxt.out.ledGreen = (nxt.st == drive_ctrl_pkg::SW_DISABLED) ? nxt.blink
                                                               : (nxt.st == drive_ctrl_pkg::OP_ENABLED);
    nxt.out.stateWord = 16'(nxt.st);
    nxt.out.stateWord[drive_ctrl_pkg::SW_LIFE] = nxt.ctrl[drive_ctrl_pkg::CW_LIFE];
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= CORE_RST;
    end else begin
      q <= nxt;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_boot;
    q.st == drive_ctrl_pkg::NOT_READY && (!q.offsAdj || offsDone) && !trip |=> q.st == drive_ctrl_pkg::SW_DISABLED;
  endproperty
  a_boot: assert property (p_boot) else $error("not-ready not left");

  property p_led;
    (q.st == drive_ctrl_pkg::OP_ENABLED |-> q.out.ledGreen)
    and (q.st != drive_ctrl_pkg::OP_ENABLED && q.st != drive_ctrl_pkg::SW_DISABLED |-> !q.out.ledGreen);
  endproperty
  a_led: assert property (p_led) else $error("indicator wrong for state");

  property p_shutdown;
    q.st == drive_ctrl_pkg::SW_DISABLED && cmd == drive_ctrl_pkg::CMD_SHUTDOWN && !trip
      |=> q.st == drive_ctrl_pkg::READY;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown not taken");

  property p_switch_on;
    q.st == drive_ctrl_pkg::READY && cmd == drive_ctrl_pkg::CMD_SWITCH && !trip
      |=> q.st == drive_ctrl_pkg::SWITCHED_ON;
  endproperty
  a_switch_on: assert property (p_switch_on) else $error("switch on not taken");

  property p_no_volt;
    q.st == drive_ctrl_pkg::SWITCHED_ON && cmd == drive_ctrl_pkg::CMD_ENABLE && !q.vSync2 && !trip
      |=> q.st == drive_ctrl_pkg::SWITCHED_ON;
  endproperty
  a_no_volt: assert property (p_no_volt) else $error("enabled without voltage");

  property p_stage;
    q.out.stageEnable |-> q.st inside {drive_ctrl_pkg::OP_ENABLED, drive_ctrl_pkg::QUICK_STOP,
      drive_ctrl_pkg::STOP_SHUTDOWN, drive_ctrl_pkg::STOP_DISABLE, drive_ctrl_pkg::FAULT_REACT};
  endproperty
  a_stage: assert property (p_stage) else $error("stage on in wrong state");

  property p_disv;
    q.st inside {drive_ctrl_pkg::OP_ENABLED, drive_ctrl_pkg::QUICK_STOP} && cmd == drive_ctrl_pkg::CMD_DISV
      && !trip |=> q.st == drive_ctrl_pkg::SW_DISABLED && !q.out.stageEnable;
  endproperty
  a_disv: assert property (p_disv) else $error("disable voltage slow");

  property p_qstop;
    q.st == drive_ctrl_pkg::OP_ENABLED && cmd == drive_ctrl_pkg::CMD_QSTOP && !trip
      |=> q.out.cancelMoves && q.out.quickRamp ##1 q.st == drive_ctrl_pkg::QUICK_STOP && !q.out.cancelMoves;
  endproperty
  a_qstop: assert property (p_qstop) else $error("quick stop wrong");

  property p_qs_hold;
    q.st == drive_ctrl_pkg::QUICK_STOP && cmd != drive_ctrl_pkg::CMD_DISV && !trip
      |=> q.st == drive_ctrl_pkg::QUICK_STOP;
  endproperty
  a_qs_hold: assert property (p_qs_hold) else $error("quick stop left early");

  property p_fault;
    trip && !(q.st inside {drive_ctrl_pkg::FAULT_REACT, drive_ctrl_pkg::FAULT})
      |=> q.st == drive_ctrl_pkg::FAULT_REACT && q.out.stopRequest;
  endproperty
  a_fault: assert property (p_fault) else $error("fault reaction missed");

  property p_fault_hold;
    q.st == drive_ctrl_pkg::FAULT && !frstRise |=> q.st == drive_ctrl_pkg::FAULT && !q.out.stageEnable;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault left without reset");

  c_enabled: cover property (q.st == drive_ctrl_pkg::OP_ENABLED);
  c_quick:   cover property (q.st == drive_ctrl_pkg::QUICK_STOP);
  c_fault:   cover property (q.st == drive_ctrl_pkg::FAULT ##[1:50] q.st == drive_ctrl_pkg::SW_DISABLED);
  c_stopdis: cover property (q.st == drive_ctrl_pkg::STOP_DISABLE);
endmodule

/* File: fieldbus_master.sv */
// Fieldbus master model issuing object reads and writes to the drive.
// Assumes ack comes one cycle after each request, with err and data beside it.
`timescale 1ns/1ps
module fieldbus_master (
  input  wire drive_ctrl_pkg::obj_rsp_t objRsp,
  input  wire logic                     core_clk,
  output drive_ctrl_pkg::obj_req_t      objReq
);
  initial objReq = '0;
  // State commands go in command-word bits 0 to 3
  task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(negedge core_clk);
    objReq <= '{1'b1, w, i, s, d};
    @(negedge core_clk);
    // Released fields carry the inverse, never the last value
    objReq <= '{1'b0, ~w, ~i, ~s, ~d};
    q = objRsp.data;
    e = objRsp.err | ~objRsp.ack;
  endtask
endmodule

/* File: drive_device_control_fsm_tb_top.sv */
// Self-checking bench for the drive device-control block.
// Assumes shortened LED and offset-adjust counts; the master model drives objReq.
`timescale 1ns/1ps
module drive_device_control_fsm_tb_top;
  logic                       core_clk = 1'b0;
  logic                       rst = 1'b1;
  logic                       voltageOk = 1'b1;
  logic [15:0]                errorEvents = 16'h0000;
  logic                       motorStopped = 1'b0;
  drive_ctrl_pkg::obj_req_t   objReq;
  drive_ctrl_pkg::obj_rsp_t   objRsp;
  drive_ctrl_pkg::drive_out_t drv;
  int                         errors = 0;
  int                         n_compared = 0;
  logic [31:0]                q;
  logic                       e;
  logic                       l;
  always #25 core_clk = ~core_clk;
  drive_device_control_fsm #(.LED_HALF_CYCLES(4), .OFFS_ADJ_CYCLES(3)) drive_device_control_fsm_inst (
    .core_clk(core_clk), .rst(rst), .objReq(objReq), .objRsp(objRsp), .voltageOk(voltageOk),
    .errorEvents(errorEvents), .motorStopped(motorStopped), .drv(drv));
  fieldbus_master fieldbus_master_inst (.objRsp(objRsp), .core_clk(core_clk), .objReq(objReq));
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic end_sim;
    $display("Counts: %0d compared, %0d mismatches", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic [31:0] x, input logic ex);
    fieldbus_master_inst.xfer(1'b0, i, s, 32'h0000_0000, q, e);
    chk(e, ex);
    if (!ex) chk(q, x);
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d, input logic ex = 1'b0);
    fieldbus_master_inst.xfer(1'b1, i, s, d, q, e);
    chk(e, ex);
  endtask
  // Bounded wait; running out ends the run
  task automatic wst(input logic [3:0] c);
    for (int k = 0; k < 16 && drv.stateWord[3:0] !== c; k++) @(negedge core_clk);
    chk(drv.stateWord[3:0], c);
    if (drv.stateWord[3:0] !== c) end_sim();
  endtask
  task automatic hold(input logic [3:0] c);
    repeat (4) @(negedge core_clk);
    chk(drv.stateWord[3:0], c);
  endtask
  task automatic t_boot;
    @(negedge core_clk);
    chk(drv.offsetAdjust, 1'b1);
    wst(4'h1);
    chk(drv.offsetAdjust, 1'b0);
    l = drv.ledGreen;
    repeat (4) @(negedge core_clk);
    chk(drv.ledGreen, !l);
    rd(16'h2350, 8'h00, 8'h05, 1'b0);
    rd(16'h2351, 8'h00, 8'h03, 1'b0);
    rd(16'h2351, 8'h01, 8'h00, 1'b0);
    rd(16'h2351, 8'h02, 16'h0800, 1'b0);
    rd(16'h2351, 8'h03, 16'h0BB8, 1'b0);
    wr(16'h2351, 8'h03, 32'h0000_0001, 1'b1);
    rd(16'h2352, 8'h00, 8'h00, 1'b1);
    rd(16'h2350, 8'h03, 16'h0002, 1'b0);
    wr(16'h2350, 8'h05, 32'hABCD_0042);
    rd(16'h2350, 8'h05, 16'h0042, 1'b0);
    wr(16'h2350, 8'h00, 32'h0000_0007, 1'b1);
    rd(16'h2350, 8'h04, 8'h00, 1'b1);
    rd(16'h2503, 8'h00, 8'h01, 1'b0);
    rd(16'h6041, 8'h00, 16'h0001, 1'b0);
    wr(16'h6041, 8'h00, 32'h0000_0004, 1'b1);
    wr(16'h2351, 8'h01, 32'h0000_0005, 1'b1);
    wr(16'h2351, 8'h01, 32'h0000_000A);
    rd(16'h2351, 8'h01, 8'h0A, 1'b0);
    wr(16'h2351, 8'h02, 32'h0001_0000);
    rd(16'h2351, 8'h02, 32'h0001_0000, 1'b0);
    $display("test boot done");
  endtask
  task automatic t_run;
    wr(16'h6040, 8'h00, 32'h0000_8006);
    wst(4'h2);
    chk(drv.stateWord[15], 1'b1);
    wr(16'h6040, 8'h00, 32'h0000_000F);
    wst(4'h4);
    chk(drv.stageEnable, 1'b1);
    chk(drv.ledGreen, 1'b1);
    wr(16'h6040, 8'h00, 32'h0000_010F);
    repeat (2) @(negedge core_clk);
    chk(drv.suspendMoves, 1'b1);
    wr(16'h6040, 8'h00, 32'h0000_000F);
    repeat (2) @(negedge core_clk);
    chk(drv.suspendMoves, 1'b0);
    wr(16'h6040, 8'h00, 32'h0000_0007);
    wst(4'h3);
    chk(drv.cancelMoves, 1'b1);
    chk(drv.stageEnable, 1'b0);
    voltageOk <= 1'b0;
    wr(16'h6040, 8'h00, 32'h0000_000F);
    hold(4'h3);
    voltageOk <= 1'b1;
    wst(4'h4);
    wr(16'h6040, 8'h00, 32'h0000_000B);
    wst(4'h5);
    chk(drv.cancelMoves, 1'b1);
    chk(drv.quickRamp, 1'b1);
    wr(16'h6040, 8'h00, 32'h0000_000F);
    hold(4'h5);
    wr(16'h6040, 8'h00, 32'h0000_0000);
    wst(4'h1);
    chk(drv.stageEnable, 1'b0);
    wr(16'h6040, 8'h00, 32'h0000_000F);
    hold(4'h1);
    $display("test run done");
  endtask
  task automatic t_fault;
    wr(16'h2321, 8'h02, 32'h0000_0001);
    rd(16'h2321, 8'h02, 16'h0001, 1'b0);
    wr(16'h6040, 8'h00, 32'h0000_0006);
    wst(4'h2);
    errorEvents <= 16'h0002;
    hold(4'h2);
    wr(16'h6040, 8'h00, 32'h0000_000F);
    wst(4'h4);
    errorEvents <= 16'h0001;
    wst(4'h8);
    chk(drv.cancelMoves, 1'b1);
    chk(drv.stopRequest, 1'b1);
    chk(drv.stageEnable, 1'b1);
    hold(4'h8);
    motorStopped <= 1'b1;
    wst(4'h9);
    chk(drv.stageEnable, 1'b0);
    // Acknowledge while the error is still active must not clear the fault
    wr(16'h6040, 8'h00, 32'h0000_0086);
    hold(4'h9);
    errorEvents <= 16'h0000;
    wr(16'h6040, 8'h00, 32'h0000_0006);
    hold(4'h9);
    wr(16'h6040, 8'h00, 32'h0000_0086);
    wst(4'h1);
    wst(4'h2);
    $display("test fault done");
  endtask
  task automatic t_stop;
    motorStopped <= 1'b0;
    wr(16'h605C, 8'h00, 32'h0000_0001);
    wr(16'h605B, 8'h00, 32'h0000_0001);
    rd(16'h605B, 8'h00, 16'h0001, 1'b0);
    wr(16'h6040, 8'h00, 32'h0000_000F);
    wst(4'h4);
    wr(16'h6040, 8'h00, 32'h0000_0007);
    wst(4'h7);
    chk(drv.cancelMoves, 1'b1);
    hold(4'h7);
    chk(drv.stopRequest, 1'b1);
    chk(drv.stageEnable, 1'b1);
    motorStopped <= 1'b1;
    wst(4'h3);
    chk(drv.stageEnable, 1'b0);
    motorStopped <= 1'b0;
    wr(16'h6040, 8'h00, 32'h0000_000F);
    wst(4'h4);
    wr(16'h6040, 8'h00, 32'h0000_0006);
    wst(4'h6);
    hold(4'h6);
    chk(drv.stopRequest, 1'b1);
    motorStopped <= 1'b1;
    wst(4'h2);
    chk(drv.stopRequest, 1'b0);
    $display("test stop done");
  endtask
  initial begin
    repeat (20) @(negedge core_clk);
    chk(32'(drv), 32'h0000_0000);
    rst <= 1'b0;
    t_boot();
    t_run();
    t_fault();
    t_stop();
    end_sim();
  end
  initial begin
    #2_000_000;
    errors++;
    end_sim();
  end
endmodule
